// [verilog/mad_pkg.sv]
// Notes on behaviour
// - Thirteen bit counter, 8K by 14 space
// - Small variant implements words 000h-3FFh
// - Large variant implements words 000h-7FFh
// - Fetches above implemented size wrap around
// - Reset vector 0000h, interrupt vector 0004h
// - Two banks, lowest 32 locations special
// - Small variant RAM at bank 0 40h-7Fh
// - Large variant RAM 20h-7Fh and A0h-BFh
// - Bank 1 F0h-FFh aliases bank 0 70h-7Fh
// - Unimplemented locations read as zero
// - Bank select bit picks bank 0 or 1
// - RAM holds 64 or 128 bytes
package mad_pkg;

  // ---------------------------------------------------------------
  // Widths and vectors
  // ---------------------------------------------------------------
  localparam int          PC_WIDTH    = 13;
  localparam int          WORD_WIDTH  = 14;
  localparam int          DATA_WIDTH  = 8;
  localparam int          DADDR_WIDTH = 8;
  localparam logic [12:0] RESET_VEC   = 13'h0000;
  localparam logic [12:0] INT_VEC     = 13'h0004;

  // ---------------------------------------------------------------
  // Program memory sizes (address bits kept)
  // ---------------------------------------------------------------
  localparam int SMALL_PBITS = 10;
  localparam int LARGE_PBITS = 11;

  // ---------------------------------------------------------------
  // Data map boundaries
  // ---------------------------------------------------------------
  localparam logic [7:0] SPECIAL_TOP   = 8'h1f;
  localparam logic [7:0] SMALL_RAM_LO  = 8'h40;
  localparam logic [7:0] LARGE_RAM_LO  = 8'h20;
  localparam logic [7:0] BANK0_RAM_HI  = 8'h7f;
  localparam logic [7:0] BANK1_RAM_LO  = 8'ha0;
  localparam logic [7:0] BANK1_RAM_HI  = 8'hbf;
  localparam logic [7:0] ALIAS_LO      = 8'hf0;
  localparam logic [7:0] ALIAS_HI      = 8'hff;
  localparam int         SMALL_BYTES   = 64;
  localparam int         LARGE_BYTES   = 128;
  localparam logic [6:0] RAM_IDX_B1    = 7'h20;

  // ---------------------------------------------------------------
  // Decode result carried between modules
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    AREA_NONE    = 3'b001,
    AREA_SPECIAL = 3'b010,
    AREA_RAM     = 3'b100
  } mad_area_type;

  typedef struct packed {
    mad_area_type area;
    logic [6:0]   ram_idx;
    logic [7:0]   addr;
  } mad_dec_type;

endpackage

// [verilog/mad_data_decode.sv]
`timescale 1ns/100ps
`default_nettype none
// Combinational data address decoder, shared by read and write paths
module mad_data_decode #(
  parameter bit LARGE = 1'b1
) (
  input  wire logic             bank_select_bit_in,
  input  wire logic [6:0]       inst_addr_in,
  output var  mad_pkg::mad_dec_type dec_out
);

  // ---------------------------------------------------------------
  // Area decode
  // ---------------------------------------------------------------
  logic [7:0] a;
  assign a = {bank_select_bit_in, inst_addr_in};

  // Bank 0 RAM index is the low seven bits; bank 1 RAM fills 00h-1Fh
  always_comb begin
    dec_out.addr    = a;
    dec_out.area    = mad_pkg::AREA_NONE;
    dec_out.ram_idx = 7'h00;
    if (inst_addr_in <= mad_pkg::SPECIAL_TOP[6:0]) begin
      dec_out.area = mad_pkg::AREA_SPECIAL;
    end else if (a >= mad_pkg::ALIAS_LO) begin
      dec_out.area    = mad_pkg::AREA_RAM;
      dec_out.ram_idx = a[6:0];
    end else if (!a[7]) begin
      if (a >= (LARGE ? mad_pkg::LARGE_RAM_LO : mad_pkg::SMALL_RAM_LO)) begin
        dec_out.area    = mad_pkg::AREA_RAM;
        dec_out.ram_idx = a[6:0];
      end
    end else if (LARGE && a >= mad_pkg::BANK1_RAM_LO &&
                 a <= mad_pkg::BANK1_RAM_HI) begin
      dec_out.area    = mad_pkg::AREA_RAM;
      dec_out.ram_idx = a[6:0] - mad_pkg::RAM_IDX_B1;
    end
  end

endmodule // mad_data_decode
`default_nettype wire

// [verilog/mad_memory_map.sv]
`timescale 1ns/100ps
`default_nettype none
// Program counter wrap, vectors and data memory of the small core
module mad_memory_map #(
  parameter bit LARGE = 1'b1
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        pc_load_in,
  input  wire logic [12:0] pc_value_in,
  input  wire logic        pc_step_in,
  input  wire logic        irq_take_in,
  input  wire logic        bank_select_bit_in,
  input  wire logic [6:0]  inst_addr_in,
  input  wire logic        data_wr_in,
  input  wire logic [7:0]  data_wdata_in,
  output logic      [12:0] pc_out,
  output logic      [10:0] fetch_addr_out,
  output logic             special_sel_out,
  output logic      [7:0]  special_addr_out,
  output logic      [7:0]  data_rdata_out
);

  // All checks run on the one clock and sleep during reset
  default clocking cb_main @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  localparam int PBITS = LARGE ? mad_pkg::LARGE_PBITS : mad_pkg::SMALL_PBITS;
  localparam int BYTES = LARGE ? mad_pkg::LARGE_BYTES : mad_pkg::SMALL_BYTES;

  // Fetch address drops counter bits above the implemented size
  function automatic logic [10:0] wrap_pc(input logic [12:0] pc);
    logic [10:0] m;
    m = (PBITS == mad_pkg::LARGE_PBITS) ? 11'h7ff : 11'h3ff;
    return pc[10:0] & m;
  endfunction

  logic [12:0] pc_nxt;
  // Interrupt outranks a load, which outranks a step
  always_comb begin
    pc_nxt = pc_out;
    if (irq_take_in) begin
      pc_nxt = mad_pkg::INT_VEC;
    end else if (pc_load_in) begin
      pc_nxt = pc_value_in;
    end else if (pc_step_in) begin
      pc_nxt = pc_out + 13'h0001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out         <= mad_pkg::RESET_VEC;
      fetch_addr_out <= 11'h000;
    end else begin
      pc_out         <= pc_nxt;
      fetch_addr_out <= wrap_pc(pc_nxt);
    end
  end

  // ---------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------
  mad_pkg::mad_dec_type dec;
  mad_data_decode #(.LARGE(LARGE)) u_dec (
    .bank_select_bit_in (bank_select_bit_in),
    .inst_addr_in       (inst_addr_in),
    .dec_out            (dec)
  );

  logic [7:0] ram [0:BYTES-1];
  logic [6:0] idx;
  // Small variant stores 40h-7Fh at index 0..63
  assign idx = LARGE ? dec.ram_idx
                     : (dec.ram_idx - mad_pkg::SMALL_RAM_LO[6:0]);

  always_ff @(posedge clock_in) begin
    if (data_wr_in && dec.area == mad_pkg::AREA_RAM) begin
      ram[idx[$clog2(BYTES)-1:0]] <= data_wdata_in;
    end
  end

  // Area flag and full address for the register file outside this block
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      special_sel_out  <= 1'b0;
      special_addr_out <= 8'h00;
    end else begin
      special_sel_out  <= (dec.area == mad_pkg::AREA_SPECIAL);
      special_addr_out <= dec.addr;
    end
  end

  // Registered read; special and unimplemented reads return zero
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_rdata_out <= 8'h00;
    end else begin
      case (dec.area)
        mad_pkg::AREA_RAM: begin
          data_rdata_out <= ram[idx[$clog2(BYTES)-1:0]];
        end
        default: begin
          data_rdata_out <= 8'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks: program counter
  // ---------------------------------------------------------------
  // Interrupt wins over a load or a step in the same cycle
  a_irq_vector: assert property (
    irq_take_in |=> pc_out == mad_pkg::INT_VEC)
    else $error("interrupt did not load vector");

  // A load without an interrupt takes the offered value
  a_pc_load: assert property (
    pc_load_in && !irq_take_in |=> pc_out == $past(pc_value_in))
    else $error("counter load wrong");

  // Step wraps from the top of the 8K space back to zero
  a_pc_step: assert property (
    pc_step_in && !pc_load_in && !irq_take_in
    |=> pc_out == $past(pc_out) + 13'h0001)
    else $error("counter step wrong");

  // With no request the counter holds its value
  a_pc_hold: assert property (
    !pc_step_in && !pc_load_in && !irq_take_in |=> $stable(pc_out))
    else $error("counter moved while idle");

  // Low fetch bits follow the counter; checked apart from wrap_pc
  a_fetch_wrap: assert property (
    fetch_addr_out[PBITS-1:0] == pc_out[PBITS-1:0])
    else $error("fetch address not wrapped");

  // Nothing above the implemented size ever reaches the memory
  a_fetch_upper: assert property (
    (fetch_addr_out >> PBITS) == 11'h000)
    else $error("fetch address above implemented size");

  // ---------------------------------------------------------------
  // Checks: data map
  // ---------------------------------------------------------------
  // Lowest 32 locations of either bank go to the register file
  a_special_low: assert property (
    inst_addr_in <= mad_pkg::SPECIAL_TOP[6:0] |=> special_sel_out)
    else $error("special area not decoded");

  // Special reads return zero here; the real value comes from outside
  a_special_zero: assert property (
    dec.area == mad_pkg::AREA_SPECIAL |=> data_rdata_out == 8'h00)
    else $error("special read nonzero");

  // Full data address is the bank bit above the seven address bits
  a_bank_addr: assert property (
    1'b1 |=> special_addr_out == $past({bank_select_bit_in, inst_addr_in}))
    else $error("bank bit not placed");

  // Upper half of bank 0 is RAM on both variants
  a_ram_range: assert property (
    !bank_select_bit_in && inst_addr_in >= mad_pkg::SMALL_RAM_LO[6:0]
    |-> dec.area == mad_pkg::AREA_RAM)
    else $error("bank 0 RAM not decoded");

  // Bank 0 20h-3Fh is RAM on the large variant only
  a_low_ram: assert property (
    !bank_select_bit_in && inst_addr_in >= mad_pkg::LARGE_RAM_LO[6:0]
    && inst_addr_in < mad_pkg::SMALL_RAM_LO[6:0]
    |-> dec.area == (LARGE ? mad_pkg::AREA_RAM : mad_pkg::AREA_NONE))
    else $error("bank 0 low RAM decode wrong");

  // Bank 1 A0h-BFh is RAM on the large variant only
  a_bank1_ram: assert property (
    bank_select_bit_in && inst_addr_in >= mad_pkg::LARGE_RAM_LO[6:0]
    && inst_addr_in < mad_pkg::SMALL_RAM_LO[6:0]
    |-> dec.area == (LARGE ? mad_pkg::AREA_RAM : mad_pkg::AREA_NONE))
    else $error("bank 1 RAM decode wrong");

  // Bank 1 RAM must sit below 20h so it never shares bank 0 storage
  a_bank1_index: assert property (
    LARGE && dec.area == mad_pkg::AREA_RAM && bank_select_bit_in
    && inst_addr_in < mad_pkg::ALIAS_LO[6:0]
    |-> idx < mad_pkg::LARGE_RAM_LO[6:0])
    else $error("bank 1 RAM overlaps bank 0");

  // Gap between bank 1 RAM and the mirror reads as nothing
  a_bank1_hole: assert property (
    bank_select_bit_in && inst_addr_in >= mad_pkg::SMALL_RAM_LO[6:0]
    && inst_addr_in < mad_pkg::ALIAS_LO[6:0]
    |-> dec.area == mad_pkg::AREA_NONE)
    else $error("bank 1 gap decoded");

  // Mirror addresses reuse the bank 0 index of the same low bits
  a_alias_decode: assert property (
    bank_select_bit_in && inst_addr_in >= mad_pkg::ALIAS_LO[6:0]
    |-> dec.area == mad_pkg::AREA_RAM && dec.ram_idx == inst_addr_in)
    else $error("mirror decode wrong");

  // Every RAM index stays inside the array of this variant
  a_idx_range: assert property (
    dec.area == mad_pkg::AREA_RAM |-> int'(idx) < BYTES)
    else $error("RAM index out of range");

  // Unimplemented locations read back as zero
  a_unimpl_zero: assert property (
    dec.area == mad_pkg::AREA_NONE |=> data_rdata_out == 8'h00)
    else $error("unimplemented read nonzero");

  // ---------------------------------------------------------------
  // Checks: stored data
  // ---------------------------------------------------------------
  // A RAM write, then a quiet cycle on the same location
  sequence s_ram_write;
    data_wr_in && dec.area == mad_pkg::AREA_RAM;
  endsequence

  sequence s_quiet_same;
    !data_wr_in && $stable(bank_select_bit_in) && $stable(inst_addr_in);
  endsequence

  // A bank 0 write to the top sixteen, then a bank 1 read of them
  sequence s_alias_write;
    data_wr_in && !bank_select_bit_in
    && inst_addr_in >= mad_pkg::ALIAS_LO[6:0];
  endsequence

  sequence s_alias_read;
    !data_wr_in && bank_select_bit_in && $stable(inst_addr_in);
  endsequence

  // Data written is what the next read of that location returns
  a_write_read: assert property (
    s_ram_write ##1 s_quiet_same
    |=> data_rdata_out == $past(data_wdata_in, 2))
    else $error("RAM read back wrong");

  // Bank 1 mirror returns what bank 0 stored; read is one cycle late
  a_alias_data: assert property (
    s_alias_write ##1 s_quiet_same ##1 s_alias_read
    |=> data_rdata_out == $past(data_wdata_in, 3))
    else $error("alias region mismatch");

endmodule // mad_memory_map
`default_nettype wire

// [testbench/mad_memory_map_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module mad_memory_map_tb;
  // ------------------------------------------------------------
  // Stimulus and observed outputs
  // ------------------------------------------------------------
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        pc_load_in = 1'b0;
  logic [12:0] pc_value_in = 13'h0000;
  logic        pc_step_in = 1'b0;
  logic        irq_take_in = 1'b0;
  // Reserved upper and indirect bank bits are held zero
  logic        bank_select_bit_in = 1'b0;
  logic [6:0]  inst_addr_in = 7'h00;
  logic        data_wr_in = 1'b0;
  logic [7:0]  data_wdata_in = 8'h00;
  logic [12:0] pc_out;
  logic [10:0] fetch_addr_out;
  logic [10:0] fetch_small;
  logic        special_sel_out;
  logic [7:0]  special_addr_out;
  logic [7:0]  data_rdata_out;
  logic [7:0]  rdata_small;
  int          err_count = 0;
  int          n_checks = 0;

  // Both variants see the same traffic, so one run covers both maps
  mad_memory_map #(.LARGE(1'b1)) i_mad_memory_map (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .pc_load_in(pc_load_in), .pc_value_in(pc_value_in),
    .pc_step_in(pc_step_in), .irq_take_in(irq_take_in),
    .bank_select_bit_in(bank_select_bit_in), .inst_addr_in(inst_addr_in),
    .data_wr_in(data_wr_in), .data_wdata_in(data_wdata_in), .pc_out(pc_out),
    .fetch_addr_out(fetch_addr_out), .special_sel_out(special_sel_out),
    .special_addr_out(special_addr_out), .data_rdata_out(data_rdata_out));
  mad_memory_map #(.LARGE(1'b0)) i_mad_memory_map_small (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .pc_load_in(pc_load_in), .pc_value_in(pc_value_in),
    .pc_step_in(pc_step_in), .irq_take_in(irq_take_in),
    .bank_select_bit_in(bank_select_bit_in), .inst_addr_in(inst_addr_in),
    .data_wr_in(data_wr_in), .data_wdata_in(data_wdata_in), .pc_out(),
    .fetch_addr_out(fetch_small), .special_sel_out(), .special_addr_out(),
    .data_rdata_out(rdata_small));

  always #10 clock_in = ~clock_in;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [12:0] exp,
                     input logic [12:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pulse for one edge, which updates counter and fetch address together, then wait one spare edge
  task automatic pc_op(input logic ld, input logic st, input logic irq,
                       input logic [12:0] v);
    @(posedge clock_in);
    pc_load_in <= ld;
    pc_step_in <= st;
    irq_take_in <= irq;
    pc_value_in <= v;
    @(posedge clock_in);
    pc_load_in <= 1'b0;
    pc_step_in <= 1'b0;
    irq_take_in <= 1'b0;
    @(posedge clock_in);
    #1;
  endtask

  task automatic acc(input logic b, input logic [6:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge clock_in);
    bank_select_bit_in <= b;
    inst_addr_in <= a;
    data_wr_in <= w;
    data_wdata_in <= d;
    @(posedge clock_in);
    data_wr_in <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_pc;
    pc_op(1'b1, 1'b0, 1'b0, 13'h17ff);
    chk("pc", 13'h17ff, pc_out);
    chk("fetch", 13'h07ff, fetch_addr_out);
    chk("fetch_small", 13'h03ff, fetch_small);
    pc_op(1'b0, 1'b1, 1'b0, 13'h0000);
    chk("pc", 13'h1800, pc_out);
    chk("fetch", 13'h0000, fetch_addr_out);
    chk("fetch_small", 13'h0000, fetch_small);
    pc_op(1'b1, 1'b0, 1'b1, 13'h0123);
    chk("pc", 13'h0004, pc_out);
    chk("fetch", 13'h0004, fetch_addr_out);
    pc_op(1'b1, 1'b0, 1'b0, 13'h1fff);
    chk("fetch", 13'h07ff, fetch_addr_out);
    chk("fetch_small", 13'h03ff, fetch_small);
    pc_op(1'b0, 1'b1, 1'b0, 13'h0000);
    chk("pc", 13'h0000, pc_out);
    $display("test_pc done");
  endtask

  task automatic test_data;
    acc(1'b0, 7'h70, 1'b1, 8'h55);
    acc(1'b1, 7'h70, 1'b0, 8'h00);
    chk("rdata", 13'h0055, data_rdata_out);
    chk("rdata_small", 13'h0055, rdata_small);
    acc(1'b1, 7'h20, 1'b1, 8'haa);
    acc(1'b0, 7'h20, 1'b1, 8'h11);
    acc(1'b1, 7'h20, 1'b0, 8'h00);
    chk("rdata", 13'h00aa, data_rdata_out);
    chk("rdata_small", 13'h0000, rdata_small);
    acc(1'b0, 7'h20, 1'b0, 8'h00);
    chk("rdata", 13'h0011, data_rdata_out);
    chk("rdata_small", 13'h0000, rdata_small);
    chk("special_sel", 13'h0000, special_sel_out);
    acc(1'b0, 7'h40, 1'b1, 8'h66);
    acc(1'b1, 7'h40, 1'b0, 8'h00);
    chk("rdata", 13'h0000, data_rdata_out);
    chk("rdata_small", 13'h0000, rdata_small);
    acc(1'b0, 7'h40, 1'b0, 8'h00);
    chk("rdata", 13'h0066, data_rdata_out);
    chk("rdata_small", 13'h0066, rdata_small);
    // Bank 1 RAM must survive a write to bank 0 40h
    acc(1'b1, 7'h20, 1'b0, 8'h00);
    chk("rdata", 13'h00aa, data_rdata_out);
    acc(1'b1, 7'h1f, 1'b1, 8'h77);
    chk("special_sel", 13'h0001, special_sel_out);
    chk("special_addr", 13'h009f, special_addr_out);
    chk("rdata", 13'h0000, data_rdata_out);
    $display("test_data done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is about forty cycles; this is about fifty times that
  initial begin
    #40000;
    err_count++;
    $display("BAD watchdog expected finish seen timeout");
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clock_in);
    #1;
    chk("pc_reset", 13'h0000, pc_out);
    rst_n_in <= 1'b1;
    test_pc();
    test_data();
    complete_run();
  end
endmodule // mad_memory_map_tb
`default_nettype wire
